/* File: hdl/pfc_fault_supervisor.sv */
// fault supervisor: protection sequencing, override pin and avalon register slave
`timescale 1ns/100ps
`default_nettype none
`include "pfc_fault_supervisor_map.svh"
module pfc_fault_supervisor #(
  parameter int unsigned US_DIV = `US_DIV_CYCLES,
  parameter int unsigned MS_DIV = `MS_DIV_US
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic IMBAL_IN,
  input wire logic PHASE_LOSS_IN,
  input wire logic SC_TRIP_IN,
  input wire logic IN_OV_IN,
  input wire logic IN_START_IN,
  input wire logic IN_UV_IN,
  input wire logic OUT_OV_IN,
  input wire logic OUT_UV_IN,
  input wire logic OT_WARN_IN,
  input wire logic OT_TRIP_IN,
  input wire logic OVR_PIN_IN,
  output logic OVR_PIN_OUT,
  output logic OVR_PIN_OE_OUT,
  output logic LINE_OK_OUT,
  output logic POWER_EN_OUT,
  output logic IRQ_OUT,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT
);
  localparam logic [10:0] IMB_MS = 11'(`T_IMBAL_MS);
  localparam logic [9:0] SC_US = 10'(`T_SC_US);
  localparam logic [6:0] FILT_US = 7'(`T_INOV_FILT_US);
  localparam logic [9:0] RES_US = 10'(`T_INOV_RES_US - 1);
  localparam logic [10:0] INUV_MS = 11'(`T_INUV_MS);
  localparam logic [10:0] INUV_OFF = 11'(`T_INUV_OFF_MS);
  localparam logic [10:0] OUTUV_MS = 11'(`T_OUTUV_MS);
  localparam logic [10:0] OUTUV_OFF = 11'(`T_OUTUV_OFF_MS);

  pfc_fault_supervisor_pkg::sup_regs_t r;
  pfc_fault_supervisor_pkg::sup_regs_t n;
  logic [10:0] raw_in;
  logic [10:0] sync_in;
  logic us_tick;
  logic ms_tick;
  logic s_imbal;
  logic s_loss;
  logic s_sc;
  logic s_inov;
  logic s_start;
  logic s_inuv;
  logic s_outov;
  logic s_outuv;
  logic s_otw;
  logic s_ott;
  logic s_pin;
  logic imbal;
  logic [7:0] cond;
  logic [7:0] ev_clr;
  logic go_timed;
  logic go_cond;
  logic [10:0] timed_len;

  // ************************************************************
  // input synchronisation and timebase
  // ************************************************************
  assign raw_in = {OVR_PIN_IN, OT_TRIP_IN, OT_WARN_IN, OUT_UV_IN, OUT_OV_IN, IN_UV_IN,
                   IN_START_IN, IN_OV_IN, SC_TRIP_IN, PHASE_LOSS_IN, IMBAL_IN};

  // RQ19 synchronise all comparators
  pfc_input_sync #(
    .W(11)
  ) pfc_input_sync_i (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  // RQ19 one shared prescaled timebase
  pfc_timebase #(
    .US_DIV(US_DIV),
    .MS_DIV(MS_DIV)
  ) pfc_timebase_i (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .us_tick_out(us_tick),
    .ms_tick_out(ms_tick)
  );

  assign {s_pin, s_ott, s_otw, s_outuv, s_outov, s_inuv, s_start, s_inov, s_sc, s_loss, s_imbal} = sync_in;

  // ************************************************************
  // supervisor logic
  // ************************************************************
  always_comb begin
    n = r;
    go_timed = 1'b0;
    go_cond = 1'b0;
    timed_len = '0;
    // RQ2 phase loss is imbalance
    imbal = s_imbal | s_loss;

    // RQ9 start level gates line_ok
    if (s_start) begin
      n.start_ok = 1'b1;
    end else if (s_inuv) begin
      n.start_ok = 1'b0;
    end
    // RQ1 imbalance drops line_ok
    n.line_ok = n.start_ok && !imbal;
    // RQ17 drive pin low when healthy; RQ1 RQ16 release on imbalance or warning
    n.pin_oe = !(imbal || s_otw);

    // RQ6 short-circuit blanking, retriggered while tripped
    if (s_sc) begin
      n.sc_us = SC_US;
    end else if (us_tick && r.sc_us != '0) begin
      n.sc_us = r.sc_us - 1'b1;
    end

    // RQ8 ignore over-voltage spikes under the filter time
    if (s_inov) begin
      if (us_tick && r.ovf_us != FILT_US) begin
        n.ovf_us = r.ovf_us + 1'b1;
      end
      if (r.ovf_us == FILT_US) begin
        n.inov_flt = 1'b1;
      end
    end else begin
      n.ovf_us = '0;
      n.inov_flt = 1'b0;
    end
    // RQ7 resume delay after over-voltage clears
    if (r.inov_flt) begin
      n.inov_res_us = RES_US;
    end else if (us_tick && r.inov_res_us != '0) begin
      n.inov_res_us = r.inov_res_us - 1'b1;
    end

    case (r.st)
      pfc_fault_supervisor_pkg::ST_WAIT: begin
        n.imb_ms = '0;
        n.imb_chk = 1'b0;
        n.ot_chk = 1'b0;
        n.inuv_ms = '0;
        n.outuv_ms = '0;
        // RQ9 startup only above start level
        if (r.start_ok && !imbal && !s_ott) begin
          n.st = pfc_fault_supervisor_pkg::ST_RUN;
        end
      end
      pfc_fault_supervisor_pkg::ST_RUN: begin
        // RQ3 ride through imbalance for the hold time
        if (imbal) begin
          if (ms_tick && r.imb_ms != IMB_MS) begin
            n.imb_ms = r.imb_ms + 1'b1;
          end
          // RQ18 sample the pin once when due; RQ4 low pin overrides
          if (r.imb_ms == IMB_MS && !r.imb_chk) begin
            n.imb_chk = 1'b1;
            go_cond = s_pin;
          end
        end else begin
          n.imb_ms = '0;
          n.imb_chk = 1'b0;
        end
        // RQ16 trip disables unless pin held low
        if (s_ott) begin
          if (!r.ot_chk) begin
            n.ot_chk = 1'b1;
            go_cond = go_cond | s_pin;
          end
        end else begin
          n.ot_chk = 1'b0;
        end
        // RQ10 sustained input under-voltage
        if (!s_inuv) begin
          n.inuv_ms = '0;
        end else if (ms_tick) begin
          if (r.inuv_ms == INUV_MS) begin
            go_timed = 1'b1;
            timed_len = INUV_OFF;
          end else begin
            n.inuv_ms = r.inuv_ms + 1'b1;
          end
        end
        // RQ13 RQ15 overload timer runs from the start of the ramp
        if (!s_outuv) begin
          n.outuv_ms = '0;
        end else if (ms_tick) begin
          if (r.outuv_ms == OUTUV_MS) begin
            go_timed = 1'b1;
            timed_len = (timed_len > OUTUV_OFF) ? timed_len : OUTUV_OFF;
          end else begin
            n.outuv_ms = r.outuv_ms + 1'b1;
          end
        end
        // timed off wins so the minimum off time is never cut short
        if (go_timed) begin
          n.st = pfc_fault_supervisor_pkg::ST_OFF_TIMED;
          n.off_ms = timed_len;
        end else if (go_cond) begin
          n.st = pfc_fault_supervisor_pkg::ST_OFF_COND;
        end
      end
      pfc_fault_supervisor_pkg::ST_OFF_TIMED: begin
        // RQ11 RQ14 hold off, then retry
        if (r.off_ms == '0) begin
          n.st = pfc_fault_supervisor_pkg::ST_WAIT;
        end else if (ms_tick) begin
          n.off_ms = r.off_ms - 1'b1;
        end
      end
      pfc_fault_supervisor_pkg::ST_OFF_COND: begin
        // RQ5 RQ16 restart once imbalance and heat are gone
        if (!imbal && !s_otw) begin
          n.st = pfc_fault_supervisor_pkg::ST_WAIT;
        end
      end
      default: begin
        n.st = pfc_fault_supervisor_pkg::ST_WAIT;
      end
    endcase

    // RQ6 RQ7 RQ12 gate power flow
    n.pwr_en = (n.st == pfc_fault_supervisor_pkg::ST_RUN) && n.sc_us == '0 && !n.inov_flt &&
               n.inov_res_us == '0 && !s_outov;

    // ************************************************************
    // events, mask and register slave
    // ************************************************************
    cond = '0;
    cond[`EV_IMBAL] = imbal;
    cond[`EV_SC] = s_sc;
    cond[`EV_INOV] = n.inov_flt;
    cond[`EV_INUV] = go_timed && r.inuv_ms == INUV_MS;
    cond[`EV_OUTOV] = s_outov;
    cond[`EV_OUTUV] = go_timed && r.outuv_ms == OUTUV_MS;
    cond[`EV_OTW] = s_otw;
    cond[`EV_SHUT] = go_timed || go_cond;
    n.cond_d = cond;

    ev_clr = '0;
    if (AVS_WRITE_IN && r.ack && AVS_BYTEENABLE_IN[0]) begin
      if (AVS_ADDRESS_IN == `REG_EVENT) begin
        ev_clr = AVS_WRITEDATA_IN[7:0];
      end
      if (AVS_ADDRESS_IN == `REG_MASK) begin
        n.mask = AVS_WRITEDATA_IN[7:0];
      end
    end
    // a new event beats a clear in the same cycle
    n.ev = (r.ev & ~ev_clr) | (cond & ~r.cond_d);

    // one wait cycle per access, then the answer
    n.ack = (AVS_READ_IN || AVS_WRITE_IN) && !r.ack;
    if (AVS_READ_IN && !r.ack) begin
      n.rdata = '0;
      case (AVS_ADDRESS_IN)
        `REG_STATUS: begin
          n.rdata[7:0] = r.cond_d;
          n.rdata[`STAT_STATE_LSB +: 4] = r.st;
          n.rdata[`STAT_LINE_OK] = r.line_ok;
          n.rdata[`STAT_PWR] = r.pwr_en;
          n.rdata[`STAT_PIN_OE] = r.pin_oe;
          n.rdata[`STAT_PIN] = s_pin;
        end
        `REG_EVENT: begin
          n.rdata[7:0] = r.ev;
        end
        `REG_MASK: begin
          n.rdata[7:0] = r.mask;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r <= '0;
      r.st <= pfc_fault_supervisor_pkg::ST_WAIT;
      r.mask <= `MASK_RST;
    end else begin
      r <= n;
    end
  end

  // open drain: only ever pulls low
  assign OVR_PIN_OUT = 1'b0;
  assign OVR_PIN_OE_OUT = r.pin_oe;
  assign LINE_OK_OUT = r.line_ok;
  assign POWER_EN_OUT = r.pwr_en;
  assign IRQ_OUT = |(r.ev & r.mask);
  assign AVS_READDATA_OUT = r.rdata;
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !r.ack;

  // ************************************************************
  // assertions
  // ************************************************************
  a_imbal_line_pin: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ1
    s_imbal |=> !LINE_OK_OUT && !OVR_PIN_OE_OUT) else $error("imbalance kept line_ok or pin drive");
  a_phase_loss: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ2
    s_loss && !s_imbal |=> !LINE_OK_OUT && !OVR_PIN_OE_OUT) else $error("phase loss not treated as imbalance");
  a_imbal_ride: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ3
    r.st == pfc_fault_supervisor_pkg::ST_RUN && imbal && r.imb_ms != IMB_MS && !s_ott && !s_inuv && !s_outuv
    |=> r.st == pfc_fault_supervisor_pkg::ST_RUN) else $error("shut down before imbalance hold time");
  a_imbal_shut: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ18
    r.st == pfc_fault_supervisor_pkg::ST_RUN && imbal && r.imb_ms == IMB_MS && !r.imb_chk && s_pin && !s_inuv
    && !s_outuv |=> r.st == pfc_fault_supervisor_pkg::ST_OFF_COND) else $error("imbalance shutdown missed");
  a_override_keep: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ4
    r.st == pfc_fault_supervisor_pkg::ST_RUN && !s_pin && !s_inuv && !s_outuv
    |=> r.st == pfc_fault_supervisor_pkg::ST_RUN) else $error("shut down while override pin held low");
  a_cond_restart: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ5
    r.st == pfc_fault_supervisor_pkg::ST_OFF_COND && !imbal && !s_otw
    |=> r.st == pfc_fault_supervisor_pkg::ST_WAIT) else $error("no automatic restart");
  a_sc_blank: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ6
    s_sc |=> r.sc_us == SC_US && !POWER_EN_OUT) else $error("short-circuit trip did not block power");
  a_inov_block: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ7
    r.inov_flt |=> !POWER_EN_OUT && r.inov_res_us == RES_US) else $error("over-voltage did not block power");
  a_inov_filter: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ8
    s_inov && r.ovf_us != FILT_US |=> !r.inov_flt) else $error("over-voltage spike passed the filter");
  // a run already under way may go on; only a fresh start is barred
  a_start_gate: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ9
    !r.start_ok && !s_start |=> !LINE_OK_OUT
    && (r.st != pfc_fault_supervisor_pkg::ST_RUN || $past(r.st) == pfc_fault_supervisor_pkg::ST_RUN))
    else $error("started below start level");
  a_inuv_shut: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ10
    r.st == pfc_fault_supervisor_pkg::ST_RUN && s_inuv && ms_tick && r.inuv_ms == INUV_MS
    |=> r.st == pfc_fault_supervisor_pkg::ST_OFF_TIMED && r.off_ms == INUV_OFF)
    else $error("no under-voltage shutdown");
  a_off_hold: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ11
    r.st == pfc_fault_supervisor_pkg::ST_OFF_TIMED && r.off_ms != '0
    |=> r.st == pfc_fault_supervisor_pkg::ST_OFF_TIMED && !POWER_EN_OUT) else $error("off time cut short");
  a_out_ov: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ12
    s_outov |=> !POWER_EN_OUT) else $error("output over-voltage kept conversion on");
  a_outuv_shut: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ13
    r.st == pfc_fault_supervisor_pkg::ST_RUN && s_outuv && ms_tick && r.outuv_ms == OUTUV_MS
    |=> r.st == pfc_fault_supervisor_pkg::ST_OFF_TIMED && r.off_ms >= OUTUV_OFF) else $error("no overload shutdown");
  a_pin_drive: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ17
    !imbal && !s_otw |=> OVR_PIN_OE_OUT) else $error("pin not driven low while healthy");
  a_tick_align: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // RQ19
    ms_tick |-> us_tick) else $error("ms tick off the us timebase");
endmodule
`default_nettype wire

/* File: hdl/pfc_fault_supervisor_map.svh */
// offsets, field positions, reset values and timing counts of the pfc fault supervisor
// Summary of operation
// RQ1: on phase imbalance drop line_ok and release the override pin.
// RQ2: a lost input phase counts as excessive imbalance.
// RQ3: keep power 0.25 s during imbalance, then shut down if still present.
// RQ4: outside party holding override pin low skips the imbalance shutdown.
// RQ5: when line is normal again drive override pin low and restart alone.
// RQ6: short-circuit trip blocks input power about 200 us, then resumes.
// RQ7: input over-voltage blocks power; resume 1 ms after it falls back.
// RQ8: input over-voltage spikes under 80 us may be filtered out.
// RQ9: no line_ok and no startup before input exceeds start level.
// RQ10: input under-voltage lasting more than one second shuts down.
// RQ11: after input under-voltage shutdown stay off at least one second.
// RQ12: output over-voltage disables conversion; resume as soon as it clears.
// RQ13: output below quarter nominal over 150 ms means overload shutdown.
// RQ14: after output under-voltage shutdown restart after one second.
// RQ15: output under-voltage timer also runs during the startup ramp.
// RQ16: temperature warning releases pin; trip disables; restart below warning.
// RQ17: normally the override pin is actively driven low as healthy status.
// RQ18: when a shutdown is due sample the pin; shut down only if high; input and output under-voltage shutdowns ignore the pin.
// RQ19: all timeouts from one prescaled timebase; comparator inputs synchronised.
`ifndef PFC_FAULT_SUPERVISOR_MAP_SVH
`define PFC_FAULT_SUPERVISOR_MAP_SVH

`define CLK_HZ 125000000
`define US_DIV_CYCLES (`CLK_HZ / 1000000)
`define MS_DIV_US 1000
`define T_IMBAL_MS 250
`define T_SC_US 200
`define T_INOV_FILT_US 80
`define T_INOV_RES_MS 1
`define T_INOV_RES_US (`T_INOV_RES_MS * 1000)
`define T_INUV_MS 1000
`define T_INUV_OFF_MS 1000
`define T_OUTUV_MS 150
`define T_OUTUV_OFF_MS 1000

`define REG_STATUS 4'h0
`define REG_EVENT 4'h4
`define REG_MASK 4'h8
`define MASK_RST 8'h00

`define EV_IMBAL 0
`define EV_SC 1
`define EV_INOV 2
`define EV_INUV 3
`define EV_OUTOV 4
`define EV_OUTUV 5
`define EV_OTW 6
`define EV_SHUT 7
`define STAT_STATE_LSB 8
`define STAT_LINE_OK 12
`define STAT_PWR 13
`define STAT_PIN_OE 14
`define STAT_PIN 15

`endif

/* File: hdl/pfc_fault_supervisor_pkg.sv */
// types of the pfc fault supervisor
package pfc_fault_supervisor_pkg;

  typedef enum logic [3:0] {
    ST_WAIT = 4'h1,
    ST_RUN = 4'h2,
    ST_OFF_TIMED = 4'h4,
    ST_OFF_COND = 4'h8
  } sup_state_t;

  typedef struct packed {
    sup_state_t st;
    logic [10:0] imb_ms;
    logic imb_chk;
    logic ot_chk;
    logic [9:0] sc_us;
    logic [6:0] ovf_us;
    logic inov_flt;
    logic [9:0] inov_res_us;
    logic [10:0] inuv_ms;
    logic [10:0] outuv_ms;
    logic [10:0] off_ms;
    logic start_ok;
    logic line_ok;
    logic pin_oe;
    logic pwr_en;
    logic [7:0] ev;
    logic [7:0] mask;
    logic [7:0] cond_d;
    logic ack;
    logic [31:0] rdata;
  } sup_regs_t;

endpackage

/* File: hdl/pfc_input_sync.sv */
// two-stage synchroniser for the comparator and pin inputs
`timescale 1ns/100ps
`default_nettype none
module pfc_input_sync #(
  parameter int unsigned W = 11
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_regs_t;

  sync_regs_t r;
  sync_regs_t n;

  always_comb begin
    n.s1 = async_in;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.s2;
endmodule
`default_nettype wire

/* File: hdl/pfc_timebase.sv */
// microsecond and millisecond tick prescaler
`timescale 1ns/100ps
`default_nettype none
`include "pfc_fault_supervisor_map.svh"
module pfc_timebase #(
  parameter int unsigned US_DIV = `US_DIV_CYCLES,
  parameter int unsigned MS_DIV = `MS_DIV_US
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  output logic us_tick_out,
  output logic ms_tick_out
);
  localparam int UW = $clog2(US_DIV + 1);
  localparam int MW = $clog2(MS_DIV + 1);

  typedef struct packed {
    logic [UW-1:0] us_cnt;
    logic [MW-1:0] ms_cnt;
    logic us_tick;
    logic ms_tick;
  } tb_regs_t;

  tb_regs_t r;
  tb_regs_t n;

  // ms tick always lands on a us tick
  always_comb begin
    n = r;
    n.us_tick = 1'b0;
    n.ms_tick = 1'b0;
    if (r.us_cnt == UW'(US_DIV - 1)) begin
      n.us_cnt = '0;
      n.us_tick = 1'b1;
      if (r.ms_cnt == MW'(MS_DIV - 1)) begin
        n.ms_cnt = '0;
        n.ms_tick = 1'b1;
      end else begin
        n.ms_cnt = r.ms_cnt + 1'b1;
      end
    end else begin
      n.us_cnt = r.us_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign us_tick_out = r.us_tick;
  assign ms_tick_out = r.ms_tick;
endmodule
`default_nettype wire

/* File: sim/pfc_host_model.sv */
// host side of the override pin: pull-up resistor plus an optional hold-low switch
`timescale 1ns/100ps
`default_nettype none
module pfc_host_model (
  input wire logic dev_oe_in,
  input wire logic dev_data_in,
  input wire logic hold_low_in,
  output logic pin_out
);
  // device drive or host hold pulls pin low
  // a released pin with no holder floats up to the pull-up level
  assign pin_out = ((dev_oe_in && !dev_data_in) || hold_low_in) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: sim/pfc_fault_supervisor_test.sv */
// self-checking bench of the pfc fault supervisor
`timescale 1ns/100ps
`default_nettype none
`include "pfc_fault_supervisor_map.svh"
module pfc_fault_supervisor_test;
  logic clk, resetn, imbal, ploss, sc, inov, start, inuv, outov, outuv, otw, ott, hold;
  logic pin, pin_d, oe, line_ok, pwr, irq, rd, wr, waitreq;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata;
  int failures = 0;
  int cmp_count = 0;

  // ****************************************
  // design and host model
  // ****************************************
  // short prescaler: 1 us = 2 cycles, 1 ms = 8 cycles
  pfc_fault_supervisor #(.US_DIV(2), .MS_DIV(4)) pfc_fault_supervisor_i (
    .CLK_IN(clk), .RESETN_IN(resetn), .IMBAL_IN(imbal), .PHASE_LOSS_IN(ploss),
    .SC_TRIP_IN(sc), .IN_OV_IN(inov), .IN_START_IN(start), .IN_UV_IN(inuv),
    .OUT_OV_IN(outov), .OUT_UV_IN(outuv), .OT_WARN_IN(otw), .OT_TRIP_IN(ott),
    .OVR_PIN_IN(pin), .OVR_PIN_OUT(pin_d), .OVR_PIN_OE_OUT(oe), .LINE_OK_OUT(line_ok),
    .POWER_EN_OUT(pwr), .IRQ_OUT(irq), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq));
  pfc_host_model pfc_host_model_i (.dev_oe_in(oe), .dev_data_in(pin_d), .hold_low_in(hold), .pin_out(pin));

  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // 0 power enable, 1 line good, 2 pin drive
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = pwr;
      1: pick = line_ok;
      default: pick = oe;
    endcase
  endfunction

  task automatic steady(input int sel, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      if (pick(sel) !== v) break;
    end
    if (n > 0) check({31'h0, pick(sel)}, {31'h0, v});
  endtask

  // must not change before lo cycles, must change by hi cycles
  task automatic goes(input int sel, input logic v, input int lo, input int hi);
    int i;
    steady(sel, !v, lo);
    for (i = lo; i < hi; i++) begin
      @(negedge clk);
      if (pick(sel) === v) begin
        cmp_count++;
        return;
      end
    end
    failures++;
    $display("wrong value at %0t: got %0h expected %0h", $time, pick(sel), v);
    test_done();
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    int i;
    @(posedge clk);
    addr <= a;
    wdata <= wd;
    rd <= !w;
    wr <= w;
    // answer is taken at the rising edge that sees waitrequest low
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (i == 50) begin
      failures++;
      test_done();
    end
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_start;
    steady(1, 1'b0, 40);
    steady(0, 1'b0, 1);
    steady(2, 1'b1, 1);
    @(posedge clk);
    start <= 1'b1;
    goes(1, 1'b1, 0, 10);
    goes(0, 1'b1, 0, 10);
  endtask

  task automatic t_short;
    @(posedge clk);
    sc <= 1'b1;
    goes(0, 1'b0, 0, 8);
    repeat (10) @(posedge clk);
    sc <= 1'b0;
    goes(0, 1'b1, 380, 430);
  endtask

  task automatic t_outov;
    @(posedge clk);
    outov <= 1'b1;
    goes(0, 1'b0, 0, 8);
    repeat (20) @(posedge clk);
    outov <= 1'b0;
    goes(0, 1'b1, 0, 8);
  endtask

  task automatic t_inov;
    @(posedge clk);
    inov <= 1'b1;
    repeat (100) @(posedge clk);
    inov <= 1'b0;
    steady(0, 1'b1, 200);
    @(posedge clk);
    inov <= 1'b1;
    goes(0, 1'b0, 150, 200);
    repeat (50) @(posedge clk);
    inov <= 1'b0;
    goes(0, 1'b1, 1960, 2040);
  endtask

  task automatic t_imbal_hold;
    @(posedge clk);
    hold <= 1'b1;
    imbal <= 1'b1;
    goes(1, 1'b0, 0, 8);
    goes(2, 1'b0, 0, 8);
    steady(0, 1'b1, 2300);
    @(posedge clk);
    imbal <= 1'b0;
    hold <= 1'b0;
    goes(2, 1'b1, 0, 10);
    goes(1, 1'b1, 0, 10);
  endtask

  task automatic t_phase_loss;
    @(posedge clk);
    ploss <= 1'b1;
    goes(1, 1'b0, 0, 8);
    goes(0, 1'b0, 1950, 2060);
    @(posedge clk);
    ploss <= 1'b0;
    goes(0, 1'b1, 0, 20);
  endtask

  task automatic t_temp;
    @(posedge clk);
    otw <= 1'b1;
    goes(2, 1'b0, 0, 8);
    @(posedge clk);
    ott <= 1'b1;
    goes(0, 1'b0, 0, 10);
    @(posedge clk);
    ott <= 1'b0;
    otw <= 1'b0;
    goes(0, 1'b1, 0, 20);
    goes(2, 1'b1, 0, 10);
  endtask

  task automatic t_out_uv;
    @(posedge clk);
    outuv <= 1'b1;
    goes(0, 1'b0, 1150, 1260);
    @(posedge clk);
    outuv <= 1'b0;
    goes(0, 1'b1, 7900, 8100);
  endtask

  // restart into a shorted output must trip again
  task automatic t_in_uv;
    @(posedge clk);
    inuv <= 1'b1;
    start <= 1'b0;
    goes(0, 1'b0, 7950, 8100);
    @(posedge clk);
    inuv <= 1'b0;
    start <= 1'b1;
    outuv <= 1'b1;
    goes(0, 1'b1, 7900, 8100);
    goes(0, 1'b0, 1150, 1260);
    @(posedge clk);
    outuv <= 1'b0;
    goes(0, 1'b1, 7900, 8100);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    bus(1'b0, `REG_EVENT, 32'h0, d);
    check(d, 32'h000000FF);
    bus(1'b0, `REG_MASK, 32'h0, d);
    check(d, {24'h0, `MASK_RST});
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `REG_MASK, 32'h00000002, d);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    // a write without the low byte lane must be ignored
    @(posedge clk);
    be <= 4'hE;
    bus(1'b1, `REG_MASK, 32'h00000000, d);
    be <= 4'hF;
    bus(1'b0, `REG_MASK, 32'h0, d);
    check(d, 32'h00000002);
    bus(1'b1, `REG_EVENT, 32'h00000002, d);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, `REG_EVENT, 32'h0, d);
    check(d, 32'h000000FD);
    bus(1'b0, 4'hC, 32'h0, d);
    check(d, 32'h0);
    bus(1'b0, `REG_STATUS, 32'h0, d);
    check(d, 32'h00007200);
    check({31'h0, pin_d}, 32'h0);
  endtask

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {resetn, imbal, ploss, sc, inov, start, inuv, outov, outuv, otw, ott, hold, rd, wr} = '0;
    addr = 4'h0;
    be = 4'hF;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_start();
    t_short();
    t_outov();
    t_inov();
    t_imbal_hold();
    t_phase_loss();
    t_temp();
    t_out_uv();
    t_in_uv();
    t_regs();
    test_done();
  end
endmodule
`default_nettype wire
